/* File: hw/rss_pkg.sv */
// Purpose: Shared constants of the reference select and status registers.
// Assumes: Byte wide register port, printed offsets are byte addresses.
// Notes: Banked window 0x20 to 0x3f holds one copy per timing generator.
package rss_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] RSS_REF_INFO_LO = 8'h14;
  localparam logic [7:0] RSS_REF_INFO_HI = 8'h15;
  localparam logic [7:0] RSS_ACT_LO = 8'h16;
  localparam logic [7:0] RSS_ACT_HI = 8'h17;
  localparam logic [7:0] RSS_QUAL_LO = 8'h18;
  localparam logic [7:0] RSS_QUAL_HI = 8'h19;
  localparam logic [7:0] RSS_EVT_FLAGS = 8'h1a;
  localparam logic [7:0] RSS_EVT_MASK = 8'h1b;
  localparam logic [7:0] RSS_IRQ_CFG = 8'h1c;
  localparam logic [7:0] RSS_PRESEL = 8'h1d;
  localparam logic [7:0] RSS_PIN_LEVEL = 8'h1e;
  localparam logic [7:0] RSS_BANK_SEL = 8'h1f;
  localparam logic [7:0] RSS_MODE_CTRL = 8'h20;
  localparam logic [7:0] RSS_LOOP_BW = 8'h21;
  localparam logic [7:0] RSS_ELECTED = 8'h22;
  localparam logic [7:0] RSS_MANUAL_REF = 8'h23;
  localparam logic [7:0] RSS_CURRENT_REF = 8'h24;
  localparam logic [7:0] RSS_DEV_HIST = 8'h25;
  localparam logic [7:0] RSS_LONG_HIST = 8'h29;
  localparam logic [7:0] RSS_SHORT_HIST = 8'h2d;
  localparam logic [7:0] RSS_USER_HIST = 8'h31;
  localparam logic [7:0] RSS_USER_HIST_MSB = 8'h34;
  localparam logic [7:0] RSS_HIST_RAMP = 8'h35;
  localparam logic [7:0] RSS_BANK_LO = 8'h20;
  localparam logic [7:0] RSS_BANK_HI = 8'h3f;
  // ==========================================================
  // Field positions
  localparam int RSS_IRQ_LEVEL_BIT = 0;
  localparam int RSS_IRQ_IDLE_BIT = 1;
  localparam int RSS_MODE_HOLD_SRC_BIT = 2;
  localparam int RSS_MODE_REVERT_BIT = 3;
  localparam int RSS_MODE_AUTO_BIT = 4;
  localparam int RSS_MODE_PULLIN_BIT = 5;
  localparam int RSS_MODE_INHERIT_BIT = 6;
  localparam int RSS_MODE_HARDWIRED_BIT = 7;
  localparam int RSS_EV_QUAL = 0;
  localparam int RSS_EV_XREF = 1;
  localparam int RSS_EV_PRI_SEL = 2;
  localparam int RSS_EV_PRI_PLL = 3;
  localparam int RSS_EV_PRI_OUT = 4;
  localparam int RSS_EV_SEC_SEL = 5;
  localparam int RSS_EV_SEC_PLL = 6;
  localparam int RSS_EV_SEC_OUT = 7;
  // ==========================================================
  // Reset values and codes
  localparam logic [7:0] RSS_LOOP_BW_RST = 8'h06;
  localparam logic [7:0] RSS_RAMP_RST = 8'h1b;
  localparam logic [3:0] RSS_FREQ_UNKNOWN = 4'he;
  localparam logic [3:0] RSS_FREQ_MANUAL = 4'hf;
  localparam logic [3:0] RSS_REF_FREERUN = 4'h0;
  localparam logic [3:0] RSS_REF_HOLDOVER = 4'hd;
  localparam logic [3:0] RSS_REF_PSEUDO_HOLD = 4'he;
  localparam logic [3:0] RSS_REF_LOCK_PRIMARY = 4'hf;
endpackage : rss_pkg

/* File: hw/rss_regs.sv */
// Purpose: Control and status registers of the reference selector.
// Assumes: Host bus front end hands over one-cycle RD/WR strobes on CLK.
// Notes: Read data appears one cycle after the read strobe.
// Function
// R1 - Reference frequency code is 4 bits: 0 none, 14 unknown, 15 manual.
// R2 - Read-only activity bit per reference plus cross reference bit.
// R3 - Read-only qualification bit per reference over two bytes.
// R4 - Eight latched event flags for qualification, cross ref and generators.
// R5 - Writing one clears that event flag only; flags reset to zero.
// R6 - Event-out flag reads one while generator event-out bits are pending.
// R7 - Mask byte enables events onto interrupt pin; resets to zero.
// R8 - Interrupt config bit 0 active level, bit 1 idle drive; reset zero.
// R9 - Hard-wired mode uses low nibble when pin low, high nibble when high.
// R10 - Preselect codes 0 freerun, 1-12 refs, 13 holdover; writable when bit7.
// R11 - Read-only bit shows source switch pin level.
// R12 - Bank bit maps 0x20-0x3f to primary (0) or secondary (1).
// R13 - Holdover source bit picks device or user history; test field zero.
// R14 - Revertive bit picks non-revertive (0) or revertive (1) selection.
// R15 - Selection bit picks manual or automatic; hard-wired bit overrides.
// R16 - Out-of-pull-in bit: 0 follow, 1 stop at pull-in boundary.
// R17 - Inheritance bit lets slave elector follow master's locked reference.
// R18 - Hard-wired switch bit exists only for primary generator.
// R19 - Loop bandwidth code per generator, resets to 6.
// R20 - Elected reference reported read-only as 4-bit code.
// R21 - Manual select read-only in hard-wired mode, shows pin-chosen ref.
// R22 - Four 32-bit histories; user history writable, resets to zero.
// R23 - Reading least significant byte latches upper bytes into holding.
// R24 - Multibyte write held until most significant byte commits it.
// R25 - Interrupt pin active when any flag and mask bit both set.
`timescale 1ns/1ns
`default_nettype none
module rss_regs
  import rss_pkg::*;
#(
  parameter int NUM_REFS = 12
) (
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic [15:0] REF_INFO_IN,
  input wire logic [NUM_REFS-1:0] REF_ACTIVE_IN,
  input wire logic XREF_ACTIVE_IN,
  input wire logic [NUM_REFS-1:0] REF_QUAL_IN,
  input wire logic [7:0] ELECTED_REF_IN,
  input wire logic [7:0] CURRENT_REF_IN,
  input wire logic [15:0] PLL_STATUS_IN,
  input wire logic [1:0] PLL_EVENT_PEND_IN,
  input wire logic [63:0] DEV_HIST_IN,
  input wire logic [63:0] LONG_HIST_IN,
  input wire logic [63:0] SHORT_HIST_IN,
  input wire logic SOURCE_SWITCH_PIN_IN,
  output logic EVENT_IRQ_PIN_OUT,
  output logic EVENT_IRQ_PIN_OE_OUT,
  output logic [15:0] MODE_CTRL_OUT,
  output logic [1:0] AUTO_SELECT_OUT,
  output logic HARD_WIRED_OUT,
  output logic [7:0] MANUAL_REF_OUT,
  output logic [15:0] LOOP_BW_OUT,
  output logic [63:0] USER_HIST_OUT,
  output logic [15:0] HIST_RAMP_OUT
);
  // ==========================================================
  // Storage
  logic [7:0] ev_flags;
  logic [7:0] ev_mask;
  logic [7:0] irq_cfg;
  logic [7:0] presel;
  logic bank;
  logic [7:0] mode_r [2];
  logic [7:0] bw_r [2];
  logic [3:0] man_r [2];
  logic [31:0] uhist_r [2];
  logic [7:0] ramp_r [2];
  logic [23:0] rd_hold;
  logic [23:0] wr_hold;
  logic sw_meta;
  logic sw_sync;
  logic primed;
  logic [NUM_REFS-1:0] qual_prev;
  logic xref_prev;
  logic [7:0] elect_prev;
  logic [15:0] pll_prev;

  // ==========================================================
  // Decode
  wire wr_evt = WR_IN && (ADDR_IN == RSS_EVT_FLAGS);
  wire wr_mask = WR_IN && (ADDR_IN == RSS_EVT_MASK);
  wire wr_cfg = WR_IN && (ADDR_IN == RSS_IRQ_CFG);
  wire wr_presel = WR_IN && (ADDR_IN == RSS_PRESEL);
  wire wr_bank = WR_IN && (ADDR_IN == RSS_BANK_SEL);
  wire wr_mode = WR_IN && (ADDR_IN == RSS_MODE_CTRL);
  wire wr_bw = WR_IN && (ADDR_IN == RSS_LOOP_BW);
  wire wr_man = WR_IN && (ADDR_IN == RSS_MANUAL_REF);
  wire wr_ramp = WR_IN && (ADDR_IN == RSS_HIST_RAMP);
  wire wr_uh_low = WR_IN && (ADDR_IN >= RSS_USER_HIST)
    && (ADDR_IN < RSS_USER_HIST_MSB);
  wire wr_uh_msb = WR_IN && (ADDR_IN == RSS_USER_HIST_MSB);
  wire [1:0] uh_idx = 2'(ADDR_IN - RSS_USER_HIST);
  // Hard-wired control lives in the primary bank only
  wire hw_mode = mode_r[0][RSS_MODE_HARDWIRED_BIT];
  // R9 pin chooses preselect nibble
  wire [3:0] pin_ref = sw_sync ? presel[7:4] : presel[3:0];

  // Per-bank views of live inputs
  wire [3:0] elect_b = bank ? ELECTED_REF_IN[7:4] : ELECTED_REF_IN[3:0];
  wire [3:0] cur_b = bank ? CURRENT_REF_IN[7:4] : CURRENT_REF_IN[3:0];
  wire [31:0] dev_b = bank ? DEV_HIST_IN[63:32] : DEV_HIST_IN[31:0];
  wire [31:0] long_b = bank ? LONG_HIST_IN[63:32] : LONG_HIST_IN[31:0];
  wire [31:0] short_b = bank ? SHORT_HIST_IN[63:32] : SHORT_HIST_IN[31:0];
  // R21 manual select shows pin choice in hard-wired mode
  wire [3:0] man_view = (!bank && hw_mode) ? pin_ref : man_r[bank];

  // ==========================================================
  // Event detection; change detectors only sample history in the first cycle after reset
  logic [7:0] ev_set;
  // R4 change detectors
  assign ev_set[RSS_EV_QUAL] = primed && (qual_prev != REF_QUAL_IN);
  assign ev_set[RSS_EV_XREF] = primed && (xref_prev != XREF_ACTIVE_IN);
  assign ev_set[RSS_EV_PRI_SEL] = primed
    && (elect_prev[3:0] != ELECTED_REF_IN[3:0]);
  assign ev_set[RSS_EV_PRI_PLL] = primed
    && (pll_prev[7:0] != PLL_STATUS_IN[7:0]);
  // R6 event-out follows pending bits as a level
  assign ev_set[RSS_EV_PRI_OUT] = PLL_EVENT_PEND_IN[0];
  assign ev_set[RSS_EV_SEC_SEL] = primed
    && (elect_prev[7:4] != ELECTED_REF_IN[7:4]);
  assign ev_set[RSS_EV_SEC_PLL] = primed
    && (pll_prev[15:8] != PLL_STATUS_IN[15:8]);
  assign ev_set[RSS_EV_SEC_OUT] = PLL_EVENT_PEND_IN[1];
  // R5 write-one-to-clear; a coincident set wins
  wire [7:0] ev_clr = wr_evt ? WDATA_IN : 8'h00;
  wire [7:0] next_ev_flags = (ev_flags & ~ev_clr) | ev_set;
  // R25 any enabled flag drives the pin active
  wire irq_any = |(ev_flags & ev_mask);

  // ==========================================================
  // Multibyte read groups
  logic mb_hit;
  logic [1:0] mb_idx;
  logic [31:0] mb_val;
  always_comb begin
    mb_hit = 1'b1;
    mb_idx = 2'h0;
    mb_val = 32'h0;
    if (ADDR_IN == RSS_REF_INFO_LO || ADDR_IN == RSS_REF_INFO_HI) begin
      // R1 frequency code rides in the upper nibble
      mb_idx = 2'(ADDR_IN - RSS_REF_INFO_LO);
      mb_val = {16'h0, REF_INFO_IN};
    end else if (ADDR_IN == RSS_ACT_LO || ADDR_IN == RSS_ACT_HI) begin
      // R2 activity bits with cross reference above
      mb_idx = 2'(ADDR_IN - RSS_ACT_LO);
      mb_val = 32'({XREF_ACTIVE_IN, REF_ACTIVE_IN});
    end else if (ADDR_IN == RSS_QUAL_LO || ADDR_IN == RSS_QUAL_HI) begin
      // R3 qualification bits
      mb_idx = 2'(ADDR_IN - RSS_QUAL_LO);
      mb_val = 32'(REF_QUAL_IN);
    end else if (ADDR_IN >= RSS_DEV_HIST && ADDR_IN < RSS_LONG_HIST) begin
      // R22 histories, banked per generator
      mb_idx = 2'(ADDR_IN - RSS_DEV_HIST);
      mb_val = dev_b;
    end else if (ADDR_IN >= RSS_LONG_HIST && ADDR_IN < RSS_SHORT_HIST) begin
      mb_idx = 2'(ADDR_IN - RSS_LONG_HIST);
      mb_val = long_b;
    end else if (ADDR_IN >= RSS_SHORT_HIST && ADDR_IN < RSS_USER_HIST) begin
      mb_idx = 2'(ADDR_IN - RSS_SHORT_HIST);
      mb_val = short_b;
    end else if (ADDR_IN >= RSS_USER_HIST && ADDR_IN <= RSS_USER_HIST_MSB)
    begin
      mb_idx = uh_idx;
      mb_val = uhist_r[bank];
    end else begin
      mb_hit = 1'b0;
    end
  end

  // Single byte registers; unmapped addresses read zero
  logic [7:0] sb_val;
  always_comb begin
    case (ADDR_IN)
      RSS_EVT_FLAGS: sb_val = ev_flags;
      RSS_EVT_MASK: sb_val = ev_mask;
      RSS_IRQ_CFG: sb_val = {6'h00, irq_cfg[1:0]};
      RSS_PRESEL: sb_val = presel;
      // R11 pin level after synchroniser
      RSS_PIN_LEVEL: sb_val = {7'h00, sw_sync};
      RSS_BANK_SEL: sb_val = {7'h00, bank};
      RSS_MODE_CTRL: sb_val = mode_r[bank];
      RSS_LOOP_BW: sb_val = bw_r[bank];
      // R20 elected reference code
      RSS_ELECTED: sb_val = {4'h0, elect_b};
      RSS_MANUAL_REF: sb_val = {4'h0, man_view};
      RSS_CURRENT_REF: sb_val = {4'h0, cur_b};
      RSS_HIST_RAMP: sb_val = ramp_r[bank];
      default: sb_val = 8'h00;
    endcase
  end

  // R23 low byte returns live data, upper bytes come from holding
  wire [7:0] next_rdata = !mb_hit ? sb_val
    : (mb_idx == 2'h0) ? mb_val[7:0]
    : rd_hold[8*(mb_idx-2'h1) +: 8];

  // Bits written to mode: hard-wired bit exists in primary bank only
  wire [7:0] mode_wval = bank ? {1'b0, WDATA_IN[6:0]} : WDATA_IN;

  // ==========================================================
  // Source switch pin synchroniser; only sw_sync is read
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sw_meta <= 1'b0;
      sw_sync <= 1'b0;
    end else begin
      sw_meta <= SOURCE_SWITCH_PIN_IN;
      sw_sync <= sw_meta;
    end
  end

  // ==========================================================
  // Event history and flags
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      primed <= 1'b0;
      qual_prev <= '0;
      xref_prev <= 1'b0;
      elect_prev <= 8'h00;
      pll_prev <= 16'h0000;
      ev_flags <= 8'h00;
    end else begin
      primed <= 1'b1;
      qual_prev <= REF_QUAL_IN;
      xref_prev <= XREF_ACTIVE_IN;
      elect_prev <= ELECTED_REF_IN;
      pll_prev <= PLL_STATUS_IN;
      ev_flags <= next_ev_flags;
    end
  end

  // ==========================================================
  // Global control registers
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ev_mask <= 8'h00;
      irq_cfg <= 8'h00;
      presel <= 8'h00;
      bank <= 1'b0;
    end else begin
      // R7 event mask
      if (wr_mask) begin
        ev_mask <= WDATA_IN;
      end
      // R8 pin configuration, upper bits unused
      if (wr_cfg) begin
        irq_cfg <= {6'h00, WDATA_IN[1:0]};
      end
      // R10 preselect only while hard-wired control is set
      if (wr_presel && hw_mode) begin
        presel <= WDATA_IN;
      end
      // R12 bank select
      if (wr_bank) begin
        bank <= WDATA_IN[0];
      end
    end
  end

  // ==========================================================
  // Banked per-generator registers
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      for (int g = 0; g < 2; g++) begin
        mode_r[g] <= 8'h00;
        bw_r[g] <= RSS_LOOP_BW_RST;
        man_r[g] <= RSS_REF_FREERUN;
        uhist_r[g] <= 32'h0;
        ramp_r[g] <= RSS_RAMP_RST;
      end
    end else begin
      // R13 R14 R16 R17 R18 mode bits, stored as written except bit 7 of the secondary bank
      if (wr_mode) begin
        mode_r[bank] <= mode_wval;
      end
      // R19 loop bandwidth code
      if (wr_bw) begin
        bw_r[bank] <= WDATA_IN;
      end
      // R21 manual select frozen in hard-wired mode
      if (wr_man && !(hw_mode && !bank)) begin
        man_r[bank] <= WDATA_IN[3:0];
      end
      // R24 commit whole value on most significant byte
      if (wr_uh_msb) begin
        uhist_r[bank] <= {WDATA_IN, wr_hold};
      end
      if (wr_ramp) begin
        ramp_r[bank] <= WDATA_IN;
      end
    end
  end

  // ==========================================================
  // Multibyte holding registers
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rd_hold <= 24'h0;
      wr_hold <= 24'h0;
    end else begin
      // R23 freeze upper bytes when low byte is read
      if (RD_IN && mb_hit && mb_idx == 2'h0) begin
        rd_hold <= mb_val[31:8];
      end
      // R24 collect lower bytes at their address offset, in any order
      if (wr_uh_low) begin
        wr_hold[8*uh_idx +: 8] <= WDATA_IN;
      end
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RDATA_OUT <= 8'h00;
      EVENT_IRQ_PIN_OUT <= 1'b1;
      EVENT_IRQ_PIN_OE_OUT <= 1'b0;
      MODE_CTRL_OUT <= 16'h0000;
      AUTO_SELECT_OUT <= 2'b00;
      HARD_WIRED_OUT <= 1'b0;
      MANUAL_REF_OUT <= 8'h00;
      LOOP_BW_OUT <= {RSS_LOOP_BW_RST, RSS_LOOP_BW_RST};
      USER_HIST_OUT <= 64'h0;
      HIST_RAMP_OUT <= {RSS_RAMP_RST, RSS_RAMP_RST};
    end else begin
      if (RD_IN) begin
        RDATA_OUT <= next_rdata;
      end
      // R25 R8 active level when enabled event, else idle state
      EVENT_IRQ_PIN_OUT <= irq_any ? irq_cfg[RSS_IRQ_LEVEL_BIT]
        : !irq_cfg[RSS_IRQ_LEVEL_BIT];
      EVENT_IRQ_PIN_OE_OUT <= irq_any || irq_cfg[RSS_IRQ_IDLE_BIT];
      MODE_CTRL_OUT <= {mode_r[1], mode_r[0]};
      // R15 hard-wired forces manual on the primary generator
      AUTO_SELECT_OUT <= {mode_r[1][RSS_MODE_AUTO_BIT],
        mode_r[0][RSS_MODE_AUTO_BIT] && !hw_mode};
      HARD_WIRED_OUT <= hw_mode;
      // R9 primary manual choice follows the pin in hard-wired mode
      MANUAL_REF_OUT <= {man_r[1], hw_mode ? pin_ref : man_r[0]};
      LOOP_BW_OUT <= {bw_r[1], bw_r[0]};
      USER_HIST_OUT <= {uhist_r[1], uhist_r[0]};
      HIST_RAMP_OUT <= {ramp_r[1], ramp_r[0]};
    end
  end

  // ==========================================================
  // Checks
  chk_evt_clear_only: assert property (@(posedge CLK_SYS_IN) // R5
    disable iff (SYS_RST_IN) (wr_evt && ev_set == 8'h00)
    |=> ev_flags == ($past(ev_flags) & ~$past(WDATA_IN)))
    else $error("event clear touched unwritten flags");
  chk_set_beats_clear: assert property (@(posedge CLK_SYS_IN) // R4
    disable iff (SYS_RST_IN) ev_set[RSS_EV_QUAL] |=> ev_flags[RSS_EV_QUAL])
    else $error("qualification event lost");
  chk_evt_out_level: assert property (@(posedge CLK_SYS_IN) // R6
    disable iff (SYS_RST_IN) PLL_EVENT_PEND_IN[1] |=> ev_flags[7])
    else $error("event-out flag not held");
  chk_irq_active_lvl: assert property (@(posedge CLK_SYS_IN) // R25
    disable iff (SYS_RST_IN) irq_any |=> EVENT_IRQ_PIN_OE_OUT
    && EVENT_IRQ_PIN_OUT == $past(irq_cfg[RSS_IRQ_LEVEL_BIT]))
    else $error("interrupt pin not at active level");
  chk_irq_idle_mode: assert property (@(posedge CLK_SYS_IN) // R8
    disable iff (SYS_RST_IN) !irq_any
    |=> EVENT_IRQ_PIN_OE_OUT == $past(irq_cfg[RSS_IRQ_IDLE_BIT]))
    else $error("interrupt idle drive wrong");
  chk_presel_locked: assert property (@(posedge CLK_SYS_IN) // R10
    disable iff (SYS_RST_IN) (wr_presel && !hw_mode) |=> $stable(presel))
    else $error("preselect written outside hard-wired mode");
  chk_secondary_no_hw: assert property (@(posedge CLK_SYS_IN) // R18
    disable iff (SYS_RST_IN) (wr_mode && bank) |=> !mode_r[1][7])
    else $error("secondary hard-wired bit set");
  chk_hist_commit: assert property (@(posedge CLK_SYS_IN) // R24
    disable iff (SYS_RST_IN) wr_uh_low
    |=> uhist_r[0] == $past(uhist_r[0]) && uhist_r[1] == $past(uhist_r[1]))
    else $error("user history changed before last byte");
  chk_read_hold: assert property (@(posedge CLK_SYS_IN) // R23
    disable iff (SYS_RST_IN) (RD_IN && ADDR_IN == RSS_DEV_HIST)
    |=> rd_hold == $past(dev_b[31:8]))
    else $error("upper history bytes not latched");
  chk_pin_choice: assert property (@(posedge CLK_SYS_IN) // R9
    disable iff (SYS_RST_IN) (hw_mode && sw_sync)
    |=> MANUAL_REF_OUT[3:0] == $past(presel[7:4]))
    else $error("pin high did not pick entry two");
endmodule : rss_regs
`default_nettype wire

/* File: testbench/rss_host_model.sv */
// Purpose: Host processor model driving the byte wide register port.
// Assumes: One-cycle strobes launched and released at rising edges.
// Notes: Released address lines show the inverse of the last value; data lines do so only after a write.
`timescale 1ns/1ns
`default_nettype none
module rss_host_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [7:0] rdata_in
);
  // ==========================================================
  // Idle bus
  // Quiet port from time zero so reset sees no strobe
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // ==========================================================
  // Byte accesses
  // one byte per strobe
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : wr_byte
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask : rd_byte
endmodule : rss_host_model
`default_nettype wire

/* File: testbench/rss_regs_tb.sv */
// Purpose: Self-checking bench for the reference select status registers.
// Assumes: Host model issues one byte access at a time.
// Notes: Event inputs move in small groups so each flag is seen clearly.
`timescale 1ns/1ns
`default_nettype none
module rss_regs_tb;
  import rss_pkg::*;
  logic clk = 1'b0, rst = 1'b1, xref = 1'b0, pin = 1'b0;
  logic wr, rd, irq, irq_oe, hard_wired;
  logic [7:0] addr, wdata, rdata, manual_ref;
  logic [7:0] elected = 8'h00, current = 8'h00;
  logic [15:0] ref_info = 16'h0000, pll_status = 16'h0000;
  logic [15:0] mode_ctrl, loop_bw, ramp;
  logic [11:0] ref_act = 12'h000, ref_qual = 12'h000;
  logic [1:0] ev_pend = 2'b00, auto_sel;
  logic [63:0] dev_hist = 64'h0, long_hist = 64'h0, short_hist = 64'h0;
  logic [63:0] user_hist;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  // ==========================================================
  // Clock, instances and watchdog
  always #5 clk = ~clk;
  rss_regs i_rss_regs (
    .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .REF_INFO_IN(ref_info),
    .REF_ACTIVE_IN(ref_act), .XREF_ACTIVE_IN(xref), .REF_QUAL_IN(ref_qual),
    .ELECTED_REF_IN(elected), .CURRENT_REF_IN(current),
    .PLL_STATUS_IN(pll_status), .PLL_EVENT_PEND_IN(ev_pend),
    .DEV_HIST_IN(dev_hist), .LONG_HIST_IN(long_hist),
    .SHORT_HIST_IN(short_hist), .SOURCE_SWITCH_PIN_IN(pin),
    .EVENT_IRQ_PIN_OUT(irq), .EVENT_IRQ_PIN_OE_OUT(irq_oe),
    .MODE_CTRL_OUT(mode_ctrl), .AUTO_SELECT_OUT(auto_sel),
    .HARD_WIRED_OUT(hard_wired), .MANUAL_REF_OUT(manual_ref),
    .LOOP_BW_OUT(loop_bw), .USER_HIST_OUT(user_hist), .HIST_RAMP_OUT(ramp));
  rss_host_model i_rss_host_model (.clk_in(clk), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
  // Run takes about 160 cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_rss_host_model.rd_byte(a, d);
    chk(d, exp);
  endtask : rdc
  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    i_rss_host_model.wr_byte(a, d);
  endtask : wrb
  // Sample on falling edges so registered outputs have landed
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // Scenarios
  // reset values
  task automatic t_reset();
    chk(irq_oe, 1'b0);
    rdc(RSS_EVT_FLAGS, 8'h00);
    rdc(RSS_EVT_MASK, 8'h00);
    rdc(RSS_IRQ_CFG, 8'h00);
    rdc(RSS_BANK_SEL, 8'h00);
    rdc(RSS_LOOP_BW, 8'h06);
    rdc(RSS_USER_HIST, 8'h00);
  endtask : t_reset
  task automatic t_status();
    @(posedge clk);
    ref_info <= {RSS_FREQ_MANUAL, 12'h123};
    ref_act <= 12'ha5c;
    ref_qual <= 12'h3c7;
    xref <= 1'b1;
    pin <= 1'b1;
    settle(6);
    rdc(RSS_REF_INFO_LO, 8'h23);
    rdc(RSS_REF_INFO_HI, 8'hf1);
    rdc(RSS_ACT_LO, 8'h5c);
    rdc(RSS_ACT_HI, 8'h1a);
    rdc(RSS_QUAL_LO, 8'hc7);
    rdc(RSS_QUAL_HI, 8'h03);
    rdc(RSS_PIN_LEVEL, 8'h01);
  endtask : t_status
  task automatic t_events();
    wrb(RSS_MODE_CTRL, 8'h10);
    wrb(RSS_EVT_FLAGS, 8'hff);
    rdc(RSS_EVT_FLAGS, 8'h00);
    @(posedge clk);
    xref <= 1'b0;
    pll_status <= 16'h0001;
    elected <= 8'h03;
    current <= 8'hf3;
    settle(3);
    rdc(RSS_EVT_FLAGS, 8'h0e);
    wrb(RSS_EVT_FLAGS, 8'h02);
    rdc(RSS_EVT_FLAGS, 8'h0c);
    wrb(RSS_EVT_MASK, 8'h08);
    wrb(RSS_IRQ_CFG, 8'h01);
    settle(3);
    chk({irq_oe, irq}, 2'b11);
    wrb(RSS_EVT_FLAGS, 8'h08);
    settle(3);
    chk(irq_oe, 1'b0);
    wrb(RSS_IRQ_CFG, 8'h02);
    settle(3);
    chk({irq_oe, irq}, 2'b11);
    wrb(RSS_EVT_MASK, 8'h04);
    settle(3);
    chk({irq_oe, irq}, 2'b10);
    @(posedge clk);
    ev_pend <= 2'b10;
    settle(3);
    wrb(RSS_EVT_FLAGS, 8'h84);
    settle(3);
    chk({irq_oe, irq}, 2'b11);
    rdc(RSS_EVT_FLAGS, 8'h80);
  endtask : t_events
  task automatic t_modes();
    wrb(RSS_MODE_CTRL, 8'h98);
    wrb(RSS_PRESEL, 8'h53);
    @(posedge clk);
    pin <= 1'b0;
    settle(6);
    chk({hard_wired, auto_sel[0]}, 2'b10);
    chk(manual_ref[3:0], 4'h3);
    rdc(RSS_MANUAL_REF, 8'h03);
    @(posedge clk);
    pin <= 1'b1;
    settle(6);
    chk(manual_ref[3:0], 4'h5);
    wrb(RSS_BANK_SEL, 8'h01);
    wrb(RSS_MODE_CTRL, 8'h98);
    wrb(RSS_LOOP_BW, 8'h0a);
    settle(3);
    chk(mode_ctrl, 16'h1898);
    chk(auto_sel, 2'b10);
    chk(loop_bw, 16'h0a06);
    rdc(RSS_MODE_CTRL, 8'h18);
    rdc(RSS_ELECTED, 8'h00);
    rdc(RSS_CURRENT_REF, 8'h0f);
    wrb(RSS_HIST_RAMP, 8'h5a);
    rdc(RSS_HIST_RAMP, 8'h5a);
    chk(ramp, {8'h5a, RSS_RAMP_RST});
    wrb(RSS_BANK_SEL, 8'h00);
    wrb(RSS_MODE_CTRL, 8'h7c);
    wrb(RSS_PRESEL, 8'h77);
    rdc(RSS_PRESEL, 8'h53);
    rdc(RSS_MODE_CTRL, 8'h7c);
    chk(auto_sel, 2'b11);
    rdc(RSS_ELECTED, 8'h03);
    rdc(RSS_CURRENT_REF, 8'h03);
  endtask : t_modes
  task automatic t_hist();
    logic [31:0] v = 32'h12345678;
    for (int i = 0; i < 3; i++) begin
      wrb(RSS_USER_HIST + 8'(i), v[8*i +: 8]);
    end
    settle(2);
    chk(user_hist[31:0], 32'h0);
    wrb(RSS_USER_HIST_MSB, v[31:24]);
    settle(2);
    chk(user_hist[31:0], v);
    for (int i = 0; i < 4; i++) begin
      rdc(RSS_USER_HIST + 8'(i), v[8*i +: 8]);
    end
    @(posedge clk);
    dev_hist <= 64'haabbccdd;
    rdc(RSS_DEV_HIST, 8'hdd);
    @(posedge clk);
    dev_hist <= 64'h11223344;
    rdc(8'h26, 8'hcc);
    rdc(8'h27, 8'hbb);
    rdc(8'h28, 8'haa);
    @(posedge clk);
    long_hist <= 64'h87654321_00000000;
    short_hist <= 64'h00000000_0000005a;
    wrb(RSS_BANK_SEL, 8'h01);
    rdc(RSS_LONG_HIST, 8'h21);
    rdc(8'h2a, 8'h43);
    rdc(RSS_SHORT_HIST, 8'h00);
    chk(user_hist[63:32], 32'h0);
  endtask : t_hist
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_status();
    t_events();
    t_modes();
    t_hist();
    close_out();
  end
endmodule : rss_regs_tb
`default_nettype wire
